// file: hdl/cmb_buffer_status.sv
// Message buffer flags, pair control, filter pointers and slot memory
// Assumes a protocol engine on ref_clk_i and an AXI4-Lite master
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`include "cmb_map.svh"

// Behaviour
// - One full flag per receive slot, 32 slots, two 16-bit registers
// - Overrun flag set when a receive targets a slot still full
// - Direction bit 1 means transmit slot, 0 means receive slot
// - Each control register covers two slots, upper and lower byte alike
// - Read-only aborted bit: 1 aborted, 0 sent successfully
// - Read-only lost arbitration bit set when arbitration was lost
// - Identifier, length, data and status words live in DMA memory; here in the block's own slot memory at 0x1000
// - Thirty-two message slots, each with its own words
// - First word: standard identifier bits 12..2, bits 15..13 read zero
// - First word bit 1 is substitute remote request
// - First word bit 0 selects extended identifier frame
// - Second word: extended identifier 17..6 in low 12 bits
// - Third word: extended id 5..0 at 15..10, length code at 3..0
// - Third word bit 9 is remote transmission request
// - Eight data bytes two per word, higher byte in upper half
// - Receive writes accepting filter number into status bits 12..8
// - Each filter has a 4-bit pointer naming the target receive slot
module cmb_buffer_status
    import cmb_pkg::*;
#(
    parameter int NSLOT = 32,
    parameter int NFILT = 16
)(
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire cmb_rx_evt_t rx_evt_i,
    input  wire cmb_tx_evt_t tx_evt_i,
    output logic [4:0]       rx_slot_o,
    output logic             rx_overrun_o,
    output logic [31:0]      tx_pending_o
);
    localparam int MEMW = NSLOT * `CMB_WORDS_PER_SLOT;

    logic [31:0]        rx_slot_full;
    logic [31:0]        rx_slot_overrun;
    logic [7:0]         slot_ctrl [NSLOT];
    logic [3:0]         filter_target_slot [NFILT];
    logic [15:0]        slot_mem [MEMW];
    cmb_bus_st_t        wst;
    cmb_bus_st_t        rst_st;
    logic [13:0]        aw_q;
    logic [31:0]        w_q;
    logic [3:0]         ws_q;
    logic               aw_got;
    logic               w_got;
    logic               do_wr;
    logic               wr_ok;
    logic [4:0]         rx_tgt;
    logic [31:0]        clr_full;
    logic [31:0]        clr_ovr;
    logic [31:0]        set_full;
    logic [31:0]        set_ovr;
    logic [31:0]        next_rdata;
    logic               next_rok;

    assign do_wr = aw_got && w_got && (wst == CMB_IDLE);
    assign rx_tgt = {1'b0, filter_target_slot[rx_evt_i.filter[3:0]]};

    // AXI write channel capture, response after both address and data
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_q          <= 14'h0000;
            w_q           <= 32'h0000_0000;
            ws_q          <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            wst           <= CMB_IDLE;
        end
        else
        begin
            s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_got && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got <= 1'b1;
                aw_q   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got <= 1'b1;
                w_q   <= s_axi_wdata;
                ws_q  <= s_axi_wstrb;
            end
            case (wst)
                CMB_IDLE:
                    if (do_wr)
                    begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
                        wst          <= CMB_RESP;
                    end
                CMB_RESP:
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        aw_got       <= 1'b0;
                        w_got        <= 1'b0;
                        wst          <= CMB_IDLE;
                    end
                default:
                    wst <= CMB_IDLE;
            endcase
        end
    end

    // Address decode for writes
    always_comb
    begin
        wr_ok    = 1'b0;
        clr_full = 32'h0000_0000;
        clr_ovr  = 32'h0000_0000;
        if (aw_q[13:2] == `CMB_OFS_FULL_LO >> 2)
        begin
            wr_ok    = 1'b1;
            clr_full = {16'h0000, ~w_q[15:0]};
        end
        else if (aw_q[13:2] == `CMB_OFS_FULL_HI >> 2)
        begin
            wr_ok    = 1'b1;
            clr_full = {~w_q[15:0], 16'h0000};
        end
        else if (aw_q[13:2] == `CMB_OFS_OVR_LO >> 2)
        begin
            wr_ok   = 1'b1;
            clr_ovr = {16'h0000, ~w_q[15:0]};
        end
        else if (aw_q[13:2] == `CMB_OFS_OVR_HI >> 2)
        begin
            wr_ok   = 1'b1;
            clr_ovr = {~w_q[15:0], 16'h0000};
        end
        else if (aw_q >= 14'(`CMB_OFS_CTRL_BASE)
                 && aw_q < 14'(`CMB_OFS_FILT_BASE))
            wr_ok = 1'b1;
        else if (aw_q >= 14'(`CMB_OFS_FILT_BASE)
                 && aw_q < 14'(`CMB_OFS_FILT_BASE) + 14'(NFILT * 4))
            wr_ok = 1'b1;
        else if (aw_q >= `CMB_OFS_MEM_BASE)
            wr_ok = 1'b1;
        if (!(do_wr && ws_q[0] && ws_q[1]))
        begin
            clr_full = 32'h0000_0000;
            clr_ovr  = 32'h0000_0000;
        end
    end

    // Receive event: set full, or overrun if the slot is still full
    always_comb
    begin
        set_full = 32'h0000_0000;
        set_ovr  = 32'h0000_0000;
        if (rx_evt_i.valid)
        begin
            if (rx_slot_full[rx_tgt])
                set_ovr[rx_tgt] = 1'b1;
            else
                set_full[rx_tgt] = 1'b1;
        end
    end

    // Writing 0 clears, writing 1 keeps; a same-cycle set wins
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rx_slot_full    <= {2{`CMB_FLAG_RST}};
            rx_slot_overrun <= {2{`CMB_FLAG_RST}};
        end
        else
        begin
            rx_slot_full    <= (rx_slot_full & ~clr_full) | set_full;
            rx_slot_overrun <= (rx_slot_overrun & ~clr_ovr) | set_ovr;
        end
    end

    // Pair control: status bits read-only, request cleared on completion
    for (genvar s = 0; s < NSLOT; s++)
    begin : g_ctrl
        localparam logic [13:0] ADDR = 14'(`CMB_OFS_CTRL_BASE + (s / 2) * 4);
        localparam int LANE = (s % 2) * 8;
        logic hit;
        logic done;
        assign hit  = do_wr && aw_q == ADDR && ws_q[LANE / 8];
        assign done = tx_evt_i.valid && tx_evt_i.slot == 5'(s);
        always_ff @(posedge ref_clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
                slot_ctrl[s] <= `CMB_CTRL_RST;
            else
            begin
                if (hit)
                begin
                    slot_ctrl[s][`CMB_BIT_DIR] <= w_q[LANE + 7];
                    slot_ctrl[s][3:0] <= w_q[LANE +: 4];
                end
                if (done)
                begin
                    slot_ctrl[s][`CMB_BIT_REQ] <= 1'b0;
                    slot_ctrl[s][`CMB_BIT_ABT] <=
                        tx_evt_i.result == CMB_TX_ABT;
                    slot_ctrl[s][`CMB_BIT_LARB] <=
                        tx_evt_i.result == CMB_TX_LARB;
                    slot_ctrl[s][`CMB_BIT_ERR] <=
                        tx_evt_i.result == CMB_TX_ERR;
                end
            end
        end
    end

    for (genvar f = 0; f < NFILT; f++)
    begin : g_filt
        always_ff @(posedge ref_clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
                filter_target_slot[f] <= 4'h0;
            else if (do_wr && aw_q == 14'(`CMB_OFS_FILT_BASE + f * 4)
                     && ws_q[0])
                filter_target_slot[f] <= w_q[3:0];
        end
    end

    // Slot memory: 8 words per slot, masked so unused bits read zero, except bits 8 and 4 of the third word, which keep what is written
    always_ff @(posedge ref_clk_i)
    begin
        if (do_wr && aw_q >= `CMB_OFS_MEM_BASE)
        begin
            case (aw_q[4:2])
                3'h0: slot_mem[aw_q[9:2]] <= w_q[15:0] & `CMB_SID_MASK;
                3'h1: slot_mem[aw_q[9:2]] <= w_q[15:0] & `CMB_EID_MASK;
                3'h2: slot_mem[aw_q[9:2]] <= w_q[15:0] & `CMB_DLC_MASK;
                3'h7: slot_mem[aw_q[9:2]] <= w_q[15:0] & `CMB_STAT_MASK;
                default: slot_mem[aw_q[9:2]] <= w_q[15:0];
            endcase
        end
        else if (rx_evt_i.valid)
            slot_mem[{rx_tgt, 3'h7}] <= {3'h0, rx_evt_i.filter, 8'h00};
    end

    // Read decode
    always_comb
    begin
        next_rok   = 1'b1;
        next_rdata = 32'h0000_0000;
        if (s_axi_araddr[13:2] == `CMB_OFS_FULL_LO >> 2)
            next_rdata = {16'h0000, rx_slot_full[15:0]};
        else if (s_axi_araddr[13:2] == `CMB_OFS_FULL_HI >> 2)
            next_rdata = {16'h0000, rx_slot_full[31:16]};
        else if (s_axi_araddr[13:2] == `CMB_OFS_OVR_LO >> 2)
            next_rdata = {16'h0000, rx_slot_overrun[15:0]};
        else if (s_axi_araddr[13:2] == `CMB_OFS_OVR_HI >> 2)
            next_rdata = {16'h0000, rx_slot_overrun[31:16]};
        else if (s_axi_araddr >= 14'(`CMB_OFS_CTRL_BASE)
                 && s_axi_araddr < 14'(`CMB_OFS_FILT_BASE))
            next_rdata = {16'h0000,
                          slot_ctrl[{s_axi_araddr[5:2], 1'b1}],
                          slot_ctrl[{s_axi_araddr[5:2], 1'b0}]};
        else if (s_axi_araddr >= 14'(`CMB_OFS_FILT_BASE)
                 && s_axi_araddr < 14'(`CMB_OFS_FILT_BASE) + 14'(NFILT * 4))
            next_rdata = {28'h0000000, filter_target_slot[s_axi_araddr[5:2]]};
        else if (s_axi_araddr >= `CMB_OFS_MEM_BASE)
            next_rdata = {16'h0000, slot_mem[s_axi_araddr[9:2]]};
        else
            next_rok = 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
            rst_st        <= CMB_IDLE;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            case (rst_st)
                CMB_IDLE:
                    if (s_axi_arvalid)
                    begin
                        s_axi_arready <= 1'b1;
                        s_axi_rdata   <= next_rdata;
                        s_axi_rresp   <= next_rok ? 2'h0 : 2'h2;
                        s_axi_rvalid  <= 1'b1;
                        rst_st        <= CMB_HOLD;
                    end
                CMB_HOLD:
                    if (s_axi_rready)
                    begin
                        s_axi_rvalid <= 1'b0;
                        rst_st       <= CMB_IDLE;
                    end
                default:
                    rst_st <= CMB_IDLE;
            endcase
        end
    end

    // Engine-side outputs
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rx_slot_o    <= 5'h00;
            rx_overrun_o <= 1'b0;
            tx_pending_o <= 32'h0000_0000;
        end
        else
        begin
            if (rx_evt_i.valid)
                rx_slot_o <= rx_tgt;
            rx_overrun_o <= |set_ovr;
            for (int i = 0; i < NSLOT; i++)
                tx_pending_o[i] <= slot_ctrl[i][`CMB_BIT_DIR]
                                   & slot_ctrl[i][`CMB_BIT_REQ];
        end
    end

    property p_full_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rx_evt_i.valid && !rx_slot_full[rx_tgt]
        |=> rx_slot_full[$past(rx_tgt)];
    endproperty
    a_full_set: assert property (p_full_set)
        else $error("full flag not set on receive");

    property p_ovr_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rx_evt_i.valid && rx_slot_full[rx_tgt]
        |=> rx_slot_overrun[$past(rx_tgt)];
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("overrun flag not set");

    property p_no_sw_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !rx_evt_i.valid |=> (rx_slot_full & ~$past(rx_slot_full)) == 32'h0;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("full flag set without receive");

    property p_ovr_hold;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        clr_ovr == 32'h0 |=> (~rx_slot_overrun & $past(rx_slot_overrun)) == 32'h0;
    endproperty
    a_ovr_hold: assert property (p_ovr_hold)
        else $error("overrun flag dropped without clear");

    property p_req_clear;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        tx_evt_i.valid |=> !slot_ctrl[$past(tx_evt_i.slot)][`CMB_BIT_REQ];
    endproperty
    a_req_clear: assert property (p_req_clear)
        else $error("send request not cleared");

    property p_abt;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        tx_evt_i.valid && tx_evt_i.result == CMB_TX_ABT
        |=> slot_ctrl[$past(tx_evt_i.slot)][`CMB_BIT_ABT];
    endproperty
    a_abt: assert property (p_abt)
        else $error("abort bit not set");

    property p_larb;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        tx_evt_i.valid && tx_evt_i.result == CMB_TX_LARB
        |=> slot_ctrl[$past(tx_evt_i.slot)][`CMB_BIT_LARB];
    endproperty
    a_larb: assert property (p_larb)
        else $error("lost arbitration bit not set");

    property p_err;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        tx_evt_i.valid && tx_evt_i.result == CMB_TX_ERR
        |=> slot_ctrl[$past(tx_evt_i.slot)][`CMB_BIT_ERR];
    endproperty
    a_err: assert property (p_err)
        else $error("bus error bit not set");
endmodule

// file: hdl/cmb_map.svh
// Register offsets, field positions and reset values of the buffer status block
// Included by the buffer status module only
`ifndef CMB_MAP_SVH
`define CMB_MAP_SVH
`define CMB_OFS_FULL_LO      8'h00
`define CMB_OFS_FULL_HI      8'h04
`define CMB_OFS_OVR_LO       8'h08
`define CMB_OFS_OVR_HI       8'h0C
`define CMB_OFS_CTRL_BASE    8'h40
`define CMB_OFS_FILT_BASE    8'h80
`define CMB_OFS_MEM_BASE     14'h1000
`define CMB_FLAG_RST         16'h0000
`define CMB_CTRL_RST         8'h00
`define CMB_BIT_DIR          7
`define CMB_BIT_ABT          6
`define CMB_BIT_LARB         5
`define CMB_BIT_ERR          4
`define CMB_BIT_REQ          3
`define CMB_BIT_RTREN        2
`define CMB_SID_MASK         16'h1FFF
`define CMB_EID_MASK         16'h0FFF
`define CMB_DLC_MASK         16'hFF1F
`define CMB_STAT_MASK        16'h1F00
`define CMB_WORDS_PER_SLOT   8
`endif

// file: hdl/cmb_pkg.sv
// Types shared by the message buffer status block
// Assumes cmb_map.svh is on the include path
package cmb_pkg;
    typedef struct packed {
        logic       valid;
        logic [4:0] filter;
    } cmb_rx_evt_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] slot;
        logic [1:0] result;
    } cmb_tx_evt_t;

    localparam logic [1:0] CMB_TX_OK   = 2'h0;
    localparam logic [1:0] CMB_TX_ABT  = 2'h1;
    localparam logic [1:0] CMB_TX_LARB = 2'h2;
    localparam logic [1:0] CMB_TX_ERR  = 2'h3;

    typedef enum logic [2:0] {
        CMB_IDLE = 3'b001,
        CMB_RESP = 3'b010,
        CMB_HOLD = 3'b100
    } cmb_bus_st_t;
endpackage

// file: verification/cmb_buffer_status_tb.sv
// Self-checking bench of the message buffer status block
// Assumes the engine model drives the event inputs
module cmb_buffer_status_tb
    import cmb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [13:0] a;
        logic [15:0] w;
        logic [15:0] e;
    } cmb_tb_row_t;

    logic        ref_clk_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic [13:0] awaddr, araddr;
    logic [31:0] wdata, rdata, pending;
    logic [3:0]  wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, rx_ovr;
    logic [1:0]  bresp, rresp, rsp;
    logic [4:0]  rx_slot;
    cmb_rx_evt_t rx_evt;
    cmb_tx_evt_t tx_evt;
    int          num_errors, tests_run, ovr_seen;
    cmb_tb_row_t rows [12] = '{
        '{14'h0000, 16'hFFFF, 16'h0000}, '{14'h0004, 16'hFFFF, 16'h0000},
        '{14'h0008, 16'hFFFF, 16'h0000}, '{14'h000C, 16'hFFFF, 16'h0000},
        '{14'h1000, 16'hFFFF, 16'h1FFF}, '{14'h1004, 16'hFFFF, 16'h0FFF},
        '{14'h1008, 16'hFEEA, 16'hFE0A},
        '{14'h100C, 16'hA55A, 16'hA55A},
        '{14'h101C, 16'hFFFF, 16'h1F00}, '{14'h13E0, 16'h0005, 16'h0005},
        '{14'h0080, 16'hFFFF, 16'h000F}, '{14'h0048, 16'hFFFF, 16'h8F8F}};

    always #25 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i)
        if (rx_ovr === 1'b1)
            ovr_seen++;

    cmb_engine_model peer (
        .ref_clk_i (ref_clk_i),
        .rx_evt_o  (rx_evt),
        .tx_evt_o  (tx_evt)
    );

    cmb_buffer_status dut (
        .ref_clk_i     (ref_clk_i),   .resetn_i      (resetn_i),
        .s_axi_awaddr  (awaddr),      .s_axi_awvalid (awvalid),
        .s_axi_awready (awready),     .s_axi_wdata   (wdata),
        .s_axi_wstrb   (wstrb),       .s_axi_wvalid  (wvalid),
        .s_axi_wready  (wready),      .s_axi_bresp   (bresp),
        .s_axi_bvalid  (bvalid),      .s_axi_bready  (bready),
        .s_axi_araddr  (araddr),      .s_axi_arvalid (arvalid),
        .s_axi_arready (arready),     .s_axi_rdata   (rdata),
        .s_axi_rresp   (rresp),       .s_axi_rvalid  (rvalid),
        .s_axi_rready  (rready),      .rx_evt_i      (rx_evt),
        .tx_evt_i      (tx_evt),      .rx_slot_o     (rx_slot),
        .rx_overrun_o  (rx_ovr),      .tx_pending_o  (pending)
    );

    task automatic close_out;
        $display("Counts: %0d checks, %0d errors", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask

    task automatic chk_rsp(string n, logic [1:0] e, logic [1:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask

    task automatic hang(string n);
        num_errors++;
        $display("Error %s expected answer seen timeout", n);
        close_out();
    endtask

    task automatic wr(logic [13:0] a, logic [31:0] d);
        int k;
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge ref_clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (k == 50) hang("bvalid");
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(logic [13:0] a, output logic [31:0] d);
        int k;
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge ref_clk_i);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (k == 50) hang("rvalid");
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rd_chk(string n, logic [13:0] a, logic [15:0] e);
        logic [31:0] d;
        rd(a, d);
        chk_val(n, e, d[15:0]);
    endtask

    initial
    begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, num_errors, tests_run, ovr_seen} = '0;
        wstrb = 4'hF;
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd_chk("ctrl_reset", 14'h0040, 16'h0000);
        foreach (rows[i])
        begin
            wr(rows[i].a, {16'h0000, rows[i].w});
            chk_rsp("row_bresp", 2'h0, rsp);
            rd_chk("row", rows[i].a, rows[i].e);
        end
        wr(14'h0048, 32'h0);
        repeat (2) @(posedge ref_clk_i);
        chk_val("pending_off", 32'h0, pending);
        $display("Test register rows done");
        wr(14'h0030, 32'h1);
        chk_rsp("unmapped_wr", 2'h2, rsp);
        rd_chk("unmapped_rd", 14'h0020, 16'h0000);
        chk_rsp("unmapped_rsp", 2'h2, rsp);
        $display("Test unmapped done");
        wr(14'h008C, 32'h5);
        peer.send_rx(5'd3);
        rd_chk("full_lo", 14'h0000, 16'h0020);
        rd_chk("filter_hit", 14'h10BC, 16'h0300);
        chk_val("rx_slot", 32'd5, rx_slot);
        chk_val("no_overrun", 32'd0, ovr_seen);
        peer.send_rx(5'd3);
        rd_chk("ovr_lo", 14'h0008, 16'h0020);
        chk_val("ovr_pulse", 32'd1, ovr_seen);
        wr(14'h0000, 32'hFFFF);
        rd_chk("ovr_held", 14'h0008, 16'h0020);
        wr(14'h0008, 32'hFFDF);
        rd_chk("ovr_clr", 14'h0008, 16'h0000);
        wr(14'h0000, 32'hFFDF);
        rd_chk("full_clr", 14'h0000, 16'h0000);
        $display("Test receive done");
        wr(14'h0040, 32'h888B);
        wr(14'h0044, 32'h888C);
        repeat (2) @(posedge ref_clk_i);
        chk_val("pending_on", 32'hF, pending);
        for (int r = 0; r < 4; r++)
            peer.send_tx(r[4:0], r[1:0]);
        repeat (2) @(posedge ref_clk_i);
        chk_val("pending_done", 32'h0, pending);
        rd_chk("ctrl_ok_abt", 14'h0040, 16'hC083);
        rd_chk("ctrl_arb_err", 14'h0044, 16'h90A4);
        $display("Test transmit done");
        wr(14'h0040, 32'h0088);
        peer.send_rx(5'd3);
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd_chk("full_rst", 14'h0000, 16'h0000);
        rd_chk("ctrl_rst", 14'h0040, 16'h0000);
        chk_val("pending_rst", 32'h0, pending);
        $display("Test second reset done");
        close_out();
    end
endmodule

// file: verification/cmb_engine_model.sv
// Protocol engine stand-in: receive and transmit completion events
// Assumes the block samples both event buses on the rising edge
module cmb_engine_model
    import cmb_pkg::*;
(
    input  wire logic  ref_clk_i,
    output cmb_rx_evt_t rx_evt_o,
    output cmb_tx_evt_t tx_evt_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        rx_evt_o = '0;
        tx_evt_o = '0;
    end

    // One accepted message; idle fields show the inverse, not stale data
    task automatic send_rx(input logic [4:0] filt);
        @(posedge ref_clk_i);
        rx_evt_o <= '{valid: 1'b1, filter: filt};
        @(posedge ref_clk_i);
        rx_evt_o <= '{valid: 1'b0, filter: ~filt};
    endtask

    // One finished transmission with its outcome code
    task automatic send_tx(input logic [4:0] slot, input logic [1:0] res);
        @(posedge ref_clk_i);
        tx_evt_o <= '{valid: 1'b1, slot: slot, result: res};
        @(posedge ref_clk_i);
        tx_evt_o <= '{valid: 1'b0, slot: ~slot, result: ~res};
    endtask
endmodule
